// File: rtl/light_sensor_mode_irq_ctrl.sv
// What this block does
// - mode 0: standby, no conversions, configuration still accepted
// - mode 3: back-to-back conversions, circuits powered, completion shown on pin only in direction 1 with functions 1-3
// - mode 1: each trigger resets auto-range, about 500us added
// - mode 2: trigger uses range history, spacing set by triggers
// - direction 0: pin is trigger input, no completion signal
// - writing 1 or 2 triggers; in direction 1 value clears after next good measurement, in direction 0 it stays
// - direction 1: pin output can announce register-triggered completion
// - triggers during a measurement are ignored
// - one-shot returns to standby; fast resume keeps circuits powered
// - pin is open-drain, active level set by polarity
// - latch 0, fault pin: on above high, off below low
// - transparent flags: high/low set inversely, hold in between
// - latch 1: flags and pin stick until flag register read
// - changes only after selected consecutive fault count; 2 means four
// - flags work in every pin function; pin shows faults only in 0
// - function 1: 1us pulse every conversion
// - function 2: 1us pulse every two conversions
// - function 3: 1us pulse every four conversions
// - fault when below low or above high on selected channel
// - threshold is result shifted left by 8 plus exponent
module light_sensor_mode_irq_ctrl #(
    parameter int RANGE_RST_CYCLES = light_ctrl_pkg::RANGE_RST_CYC
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic linkClock,
    input wire logic modeWrite,
    input wire light_ctrl_pkg::op_mode_t modeWriteData,
    input wire logic pinDirection,
    input wire logic fastResumeEn,
    input wire logic latchMode,
    input wire logic [1:0] irqPinFunction,
    input wire logic [1:0] faultCountSel,
    input wire logic irqLinePolarity,
    input wire logic compareChannelSel,
    input wire logic [light_ctrl_pkg::RES_W-1:0] highResult,
    input wire logic [light_ctrl_pkg::EXP_W-1:0] highExponent,
    input wire logic [light_ctrl_pkg::RES_W-1:0] lowResult,
    input wire logic [light_ctrl_pkg::EXP_W-1:0] lowExponent,
    input wire logic flagRead,
    input wire logic convDone,
    input wire logic [light_ctrl_pkg::CODE_W-1:0] ch0Code,
    input wire logic [light_ctrl_pkg::CODE_W-1:0] ch1Code,
    input wire logic irqPinIn,
    output logic convStart,
    output logic rangeReset,
    output logic powered,
    output light_ctrl_pkg::op_mode_t modeValue,
    output logic flagHigh,
    output logic flagLow,
    output logic irqPinOut,
    output logic irqPinOe
);
    import light_ctrl_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    // threshold widened to the linear code scale
    function automatic logic [CMP_W-1:0] thrCode(input logic [RES_W-1:0] res, input logic [EXP_W-1:0] ex);
        thrCode = {{(CMP_W-RES_W){1'b0}}, res} << (THR_SHIFT + int'(ex));
    endfunction : thrCode

    // ************************************************************
    // sequencer
    // ************************************************************
    seq_state_t state, next_state;
    logic [WAIT_W-1:0] waitCnt, next_wait;
    logic [1:0] doneCnt, next_doneCnt;
    logic [PULSE_W-1:0] pulseCnt, next_pulseCnt;
    logic [2:0] trigSync;
    logic regArmed, next_regArmed;
    logic next_convStart, next_powered;
    op_mode_t next_modeValue;
    logic regTrig, pinTrig, forceNow, sample, pinActive, trigToggle;

    // register trigger and synchronised pin trigger
    assign regTrig = modeWrite && (modeWriteData == MODE_FORCE || modeWriteData == MODE_HIST);
    assign pinTrig = (trigSync[2] ^ trigSync[1]) && !pinDirection
                     && (modeValue == MODE_FORCE || modeValue == MODE_HIST);
    assign forceNow = (regTrig ? modeWriteData : modeValue) == MODE_FORCE;
    assign sample = convDone && state == S_CONV;

    // next-state of the mode sequencer
    always_comb begin
        next_state = state;
        next_wait = waitCnt;
        next_convStart = 1'b0;
        next_powered = powered;
        next_modeValue = modeValue;
        // input-mode writes stay, so the pin can keep triggering
        next_regArmed = regArmed || (regTrig && pinDirection);
        next_doneCnt = doneCnt;
        next_pulseCnt = (pulseCnt == '0) ? pulseCnt : pulseCnt - PULSE_W'(1);
        case (state)
            S_IDLE: begin
                next_powered = powered && fastResumeEn;
                if (regTrig || pinTrig || modeValue == MODE_CONT) begin
                    // never convert with the circuits dropping away
                    next_powered = 1'b1;
                    if (!powered) begin
                        next_state = S_WAKE;
                        next_wait = WAIT_W'(WAKE_CYC - 1);
                    end else if (forceNow) begin
                        next_state = S_ARST;
                        next_wait = WAIT_W'(RANGE_RST_CYCLES - 1);
                    end else begin
                        next_state = S_CONV;
                        next_convStart = 1'b1;
                    end
                end
            end
            S_WAKE: begin
                if (waitCnt != '0) begin
                    next_wait = waitCnt - WAIT_W'(1);
                end else if (forceNow) begin
                    next_state = S_ARST;
                    next_wait = WAIT_W'(RANGE_RST_CYCLES - 1);
                end else begin
                    next_state = S_CONV;
                    next_convStart = 1'b1;
                end
            end
            S_ARST: begin
                if (waitCnt != '0) begin
                    next_wait = waitCnt - WAIT_W'(1);
                end else begin
                    next_state = S_CONV;
                    next_convStart = 1'b1;
                end
            end
            S_CONV: begin
                // triggers here are not acted on
                if (convDone) begin
                    next_doneCnt = doneCnt + 2'h1;
                    if (irqPinFunction == FN_EACH
                        || (irqPinFunction == FN_PAIR && doneCnt[0])
                        || (irqPinFunction == FN_QUAD && doneCnt == 2'h3)) begin
                        next_pulseCnt = PULSE_W'(PULSE_CYC);
                    end
                    if (modeValue == MODE_CONT) begin
                        next_convStart = 1'b1;
                    end else begin
                        next_state = S_IDLE;
                    end
                    if (regArmed) begin
                        next_modeValue = MODE_OFF;
                        next_regArmed = regTrig && pinDirection;
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // a write in the clearing cycle wins
        if (modeWrite) begin
            next_modeValue = modeWriteData;
        end
    end

    // sequencer registers and trigger synchroniser
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state <= S_IDLE;
            waitCnt <= '0;
            convStart <= 1'b0;
            rangeReset <= 1'b0;
            powered <= 1'b0;
            modeValue <= MODE_OFF;
            regArmed <= 1'b0;
            doneCnt <= '0;
            pulseCnt <= '0;
            trigSync <= '0;
        end else begin
            state <= next_state;
            waitCnt <= next_wait;
            convStart <= next_convStart;
            // range reset held during its wait
            rangeReset <= (next_state == S_ARST);
            powered <= next_powered;
            modeValue <= next_modeValue;
            regArmed <= next_regArmed;
            doneCnt <= next_doneCnt;
            pulseCnt <= next_pulseCnt;
            trigSync <= {trigSync[1:0], trigToggle};
        end
    end

    // ************************************************************
    // threshold and flags
    // ************************************************************
    logic [RUN_W-1:0] faultRun, next_faultRun, need;
    logic faultKind, next_faultKind, pinFault, next_pinFault;
    logic next_flagHigh, next_flagLow, isHigh, isLow;
    logic [CMP_W-1:0] code;

    assign code = {{(CMP_W-CODE_W){1'b0}}, compareChannelSel ? ch1Code : ch0Code};
    assign isHigh = code > thrCode(highResult, highExponent);
    assign isLow = code < thrCode(lowResult, lowExponent);
    assign need = RUN_W'(1) << faultCountSel;

    // next values of flags and fault run
    always_comb begin
        next_faultRun = faultRun;
        next_faultKind = faultKind;
        next_flagHigh = flagHigh;
        next_flagLow = flagLow;
        next_pinFault = pinFault;
        if (latchMode && flagRead) begin
            next_flagHigh = 1'b0;
            next_flagLow = 1'b0;
            next_pinFault = 1'b0;
        end
        if (sample) begin
            if (isHigh || isLow) begin
                next_faultKind = isHigh;
                if (faultKind == isHigh && faultRun != '0) begin
                    next_faultRun = (faultRun == '1) ? faultRun : faultRun + RUN_W'(1);
                end else begin
                    next_faultRun = RUN_W'(1);
                end
            end else begin
                next_faultRun = '0;
            end
            if ((isHigh || isLow) && next_faultRun >= need) begin
                if (isHigh) begin
                    next_flagHigh = 1'b1;
                    next_pinFault = 1'b1;
                    next_flagLow = latchMode ? next_flagLow : 1'b0;
                end else begin
                    next_flagLow = 1'b1;
                    next_flagHigh = latchMode ? next_flagHigh : 1'b0;
                    next_pinFault = latchMode;
                end
            end
        end
    end

    // flag registers and pin source
    always_ff @(posedge clock) begin
        if (!rstn) begin
            faultRun <= '0;
            faultKind <= 1'b0;
            flagHigh <= 1'b0;
            flagLow <= 1'b0;
            pinFault <= 1'b0;
            pinActive <= 1'b0;
        end else begin
            faultRun <= next_faultRun;
            faultKind <= next_faultKind;
            flagHigh <= next_flagHigh;
            flagLow <= next_flagLow;
            pinFault <= next_pinFault;
            // pin shows faults only in function 0
            pinActive <= (irqPinFunction == FN_FAULT) ? pinFault : (pulseCnt != '0);
        end
    end

    // ************************************************************
    // pin side, link clock
    // ************************************************************
    logic [1:0] linkRstnSync, activeSync, dirSync, polSync;
    logic [2:0] pinInSync;
    logic linkRstn, next_trigToggle, next_pinOe, asserted, assertedPrev;

    assign linkRstn = linkRstnSync[1];
    assign asserted = polSync[1] ? pinInSync[1] : !pinInSync[1];
    assign assertedPrev = polSync[1] ? pinInSync[2] : !pinInSync[2];

    // next values of the pin driver and trigger toggle
    always_comb begin
        // input mode raises a trigger event
        next_trigToggle = trigToggle ^ (!dirSync[1] && asserted && !assertedPrev);
        // open-drain drive low when line must read low
        next_pinOe = dirSync[1] && (polSync[1] ? !activeSync[1] : activeSync[1]);
    end

    // link-side synchronisers and registers
    always_ff @(posedge linkClock) begin
        linkRstnSync <= {linkRstnSync[0], rstn};
        if (!linkRstn) begin
            activeSync <= '0;
            dirSync <= '0;
            polSync <= '0;
            pinInSync <= '0;
            trigToggle <= 1'b0;
            irqPinOe <= 1'b0;
            irqPinOut <= 1'b0;
        end else begin
            activeSync <= {activeSync[0], pinActive};
            dirSync <= {dirSync[0], pinDirection};
            polSync <= {polSync[0], irqLinePolarity};
            pinInSync <= {pinInSync[1:0], irqPinIn};
            trigToggle <= next_trigToggle;
            irqPinOe <= next_pinOe;
            irqPinOut <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_off;
        @(posedge clock) disable iff (!rstn)
        (state == S_IDLE && modeValue == MODE_OFF && !modeWrite) |=> state == S_IDLE;
    endproperty
    a_off: assert property (p_off) else $error("left standby in power-down");

    property p_cont;
        @(posedge clock) disable iff (!rstn)
        (sample && modeValue == MODE_CONT) |=> convStart && state == S_CONV;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous did not restart");

    property p_force;
        @(posedge clock) disable iff (!rstn)
        $fell(rangeReset) |-> convStart && state == S_CONV;
    endproperty
    a_force: assert property (p_force) else $error("range reset not followed by start");

    property p_clear;
        @(posedge clock) disable iff (!rstn)
        (sample && regArmed && !modeWrite) |=> modeValue == MODE_OFF;
    endproperty
    a_clear: assert property (p_clear) else $error("trigger value not cleared");

    property p_busy;
        @(posedge clock) disable iff (!rstn)
        (state == S_CONV && !convDone) |=> !convStart && state == S_CONV;
    endproperty
    a_busy: assert property (p_busy) else $error("trigger taken while busy");

    property p_latch;
        @(posedge clock) disable iff (!rstn)
        (latchMode && flagHigh && !flagRead) ##1 $stable(latchMode) |-> flagHigh;
    endproperty
    a_latch: assert property (p_latch) else $error("latched flag dropped");

    property p_count;
        @(posedge clock) disable iff (!rstn)
        ($rose(flagHigh) && $stable(faultCountSel)) |-> faultRun >= need;
    endproperty
    a_count: assert property (p_count) else $error("flag set before fault count");

    property p_pulse;
        @(posedge clock) disable iff (!rstn)
        $rose(pulseCnt != '0) |-> pulseCnt == PULSE_CYC ##1 pulseCnt == PULSE_CYC - 1;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length wrong");

    property p_quad;
        @(posedge clock) disable iff (!rstn)
        ($rose(pulseCnt != '0) && irqPinFunction == FN_QUAD) |-> doneCnt == 2'h0;
    endproperty
    a_quad: assert property (p_quad) else $error("quad pulse off cadence");

    property p_input;
        @(posedge linkClock) disable iff (!linkRstn)
        !dirSync[1] |=> !irqPinOe;
    endproperty
    a_input: assert property (p_input) else $error("pin driven as input");
endmodule : light_sensor_mode_irq_ctrl

// File: shared/light_ctrl_pkg.sv
package light_ctrl_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 40;
    localparam int PULSE_NS = 1000;
    // pulse length rounds down, never below one cycle
    localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ / 1000 < 1) ? 1 : PULSE_NS * CLK_MHZ / 1000;
    localparam int RANGE_RST_US = 500;
    localparam int RANGE_RST_CYC = RANGE_RST_US * CLK_MHZ;
    // standby recovery time, plain default
    localparam int WAKE_US = 50;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int RES_W = 12;
    localparam int EXP_W = 4;
    localparam int CODE_W = 28;
    localparam int THR_SHIFT = 8;
    localparam int CMP_W = 36;
    localparam int WAIT_W = 15;
    localparam int PULSE_W = 6;
    localparam int RUN_W = 4;

    // ************************************************************
    // field encodings
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_FORCE = 2'h1,
        MODE_HIST = 2'h2,
        MODE_CONT = 2'h3
    } op_mode_t;
    localparam logic [1:0] FN_FAULT = 2'h0;
    localparam logic [1:0] FN_EACH = 2'h1;
    localparam logic [1:0] FN_PAIR = 2'h2;
    localparam logic [1:0] FN_QUAD = 2'h3;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_WAKE = 4'h2,
        S_ARST = 4'h4,
        S_CONV = 4'h8
    } seq_state_t;
endpackage : light_ctrl_pkg

// File: testbench/light_far_side.sv
// ****************************************
// converter and line model
// ****************************************
module light_far_side #(
    parameter int CONV_CYC = 10
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic convStart,
    input wire logic irqPinOe,
    input wire logic hostPull,
    input wire logic [27:0] code0,
    input wire logic [27:0] code1,
    output logic convDone,
    output logic [27:0] ch0Code,
    output logic [27:0] ch1Code,
    output wire logic irqLine
);
    timeunit 1ns;
    timeprecision 1ps;
    int left;
    logic tog;
    // conversion timer, restarts on every start pulse
    always_ff @(posedge clock) begin
        if (!rstn) begin
            left <= 0;
            convDone <= 1'b0;
            tog <= 1'b0;
        end else begin
            tog <= ~tog;
            convDone <= (left == 1);
            if (convStart) begin
                left <= CONV_CYC;
            end else if (left > 0) begin
                left <= left - 1;
            end
        end
    end
    // codes only valid with done, otherwise inverted while tog is low and passed unchanged while tog is high
    assign ch0Code = convDone ? code0 : (~code0 ^ {28{tog}});
    assign ch1Code = convDone ? code1 : (~code1 ^ {28{tog}});
    assign irqLine = (irqPinOe || hostPull) ? 1'b0 : 1'b1;
endmodule : light_far_side

// File: testbench/light_sensor_mode_irq_ctrl_bench.sv
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin numErrors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module light_sensor_mode_irq_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RST = 20;
    localparam int WAKE = light_ctrl_pkg::WAKE_CYC;
    logic clock = 0, linkClock = 0, rstn = 0, modeWrite = 0, pinDirection = 1, fastResumeEn = 0;
    logic latchMode = 0, irqLinePolarity = 0, compareChannelSel = 1, flagRead = 0, hostPull = 0;
    light_ctrl_pkg::op_mode_t modeWriteData = light_ctrl_pkg::MODE_OFF;
    light_ctrl_pkg::op_mode_t modeValue;
    logic [1:0] irqPinFunction = 0, faultCountSel = 0, lastFlags = 0;
    logic [11:0] highResult = 12'h008, lowResult = 12'h008;
    logic [3:0] highExponent = 4'h1, lowExponent = 4'h0;
    logic [27:0] code0 = 0, code1 = 28'h0000C00, ch0Code, ch1Code, mid;
    wire logic convDone, irqLine, convStart, rangeReset, powered, flagHigh, flagLow, irqPinOut, irqPinOe;
    int numErrors = 0, nTests = 0, seed = 91, cyc = 0, t0 = 0, pulseCount = 0, startCount = 0;
    bit contMode = 0;
    int latQ[$];
    int expLat;
    logic [1:0] expFlags;
    logic [1:0] flagQ[$];
    realtime oeRise;
    // ****************************************
    // clocks and instances
    // ****************************************
    initial begin
        forever #12.5 clock = ~clock;
    end
    // link clock with an unrelated phase
    initial begin
        #7;
        forever #32 linkClock = ~linkClock;
    end
    light_sensor_mode_irq_ctrl #(.RANGE_RST_CYCLES(RST)) DUT (.clock(clock), .rstn(rstn),
        .linkClock(linkClock), .modeWrite(modeWrite), .modeWriteData(modeWriteData),
        .pinDirection(pinDirection), .fastResumeEn(fastResumeEn), .latchMode(latchMode),
        .irqPinFunction(irqPinFunction), .faultCountSel(faultCountSel), .irqLinePolarity(irqLinePolarity),
        .compareChannelSel(compareChannelSel), .highResult(highResult), .highExponent(highExponent),
        .lowResult(lowResult), .lowExponent(lowExponent), .flagRead(flagRead), .convDone(convDone),
        .ch0Code(ch0Code), .ch1Code(ch1Code), .irqPinIn(irqLine), .convStart(convStart),
        .rangeReset(rangeReset), .powered(powered), .modeValue(modeValue), .flagHigh(flagHigh),
        .flagLow(flagLow), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));
    light_far_side #(.CONV_CYC(10)) farSide (.clock(clock), .rstn(rstn), .convStart(convStart),
        .irqPinOe(irqPinOe), .hostPull(hostPull), .code0(code0), .code1(code1), .convDone(convDone),
        .ch0Code(ch0Code), .ch1Code(ch1Code), .irqLine(irqLine));
    // ****************************************
    // tasks
    // ****************************************
    task automatic report_and_stop;
        $display("counts: %0d checks, %0d mismatches", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // mode write pulse; lat is the expected start latency, 0 means none expected
    task automatic trig(input logic [1:0] m, input int lat);
        @(negedge clock);
        modeWrite = 1'b1;
        modeWriteData = light_ctrl_pkg::op_mode_t'(m);
        if (lat > 0) begin
            latQ.push_back(lat);
            t0 = cyc;
        end
        @(negedge clock);
        modeWrite = 1'b0;
    endtask : trig
    // host waits for completion plus settling before the next trigger
    task automatic waitDone;
        for (int k = 0; k < 30000 && convDone !== 1'b1; k++) @(negedge clock);
        repeat (14) @(negedge clock);
    endtask : waitDone
    // one history one-shot on a powered device; channel 0 gets the opposite side
    task automatic meas(input logic [27:0] c, input logic [1:0] fl, input bit chg);
        code1 = c;
        code0 = (c > 28'h0001000) ? 28'h0 : 28'hFFFFFFF;
        if (chg) flagQ.push_back(fl);
        trig(2, 1);
        waitDone;
    endtask : meas
    task automatic readFlags(input bit chg);
        if (chg) flagQ.push_back(2'b00);
        @(negedge clock);
        flagRead = 1'b1;
        @(negedge clock);
        flagRead = 1'b0;
        repeat (14) @(negedge clock);
    endtask : readFlags
    // ****************************************
    // monitors
    // ****************************************
    // cycle count and hang limit
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            numErrors++;
            report_and_stop;
        end
    end
    // starts and flag changes are matched against the oldest note
    always @(negedge clock) begin
        if (rstn && convStart === 1'b1) begin
            startCount++;
            if (latQ.size() > 0) begin
                expLat = latQ.pop_front();
                `CHK("startLatency", expLat, cyc - t0)
            end else if (!contMode) `CHK("unexpectedStart", 1'b0, 1'b1)
        end
        if (rstn && {flagHigh, flagLow} !== lastFlags) begin
            if (flagQ.size() > 0) begin
                expFlags = flagQ.pop_front();
                `CHK("flags", expFlags, {flagHigh, flagLow})
            end else `CHK("flagsHeld", lastFlags, {flagHigh, flagLow})
            lastFlags = {flagHigh, flagLow};
        end
    end
    // pulse width on the line, only in completion functions
    always @(posedge irqPinOe) oeRise = $realtime;
    always @(negedge irqPinOe) begin
        if (irqPinFunction != 2'h0) begin
            pulseCount++;
            `CHK("pulseWidthOk", 1'b1, ($realtime - oeRise > 900.0 && $realtime - oeRise < 1100.0))
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        `CHK("resetMode", 2'h0, modeValue)
        `CHK("resetPowered", 1'b0, powered)
        // standby recovery, then circuits kept powered
        trig(2, WAKE + 1);
        waitDone;
        `CHK("dropPower", 1'b0, powered)
        fastResumeEn = 1'b1;
        trig(2, WAKE + 1);
        waitDone;
        `CHK("keepPower", 1'b1, powered)
        `CHK("modeCleared", 2'h0, modeValue)
        $display("test power done");
        // transparent flags at the threshold boundaries
        meas(28'h00007FF, 2'b01, 1);
        meas(28'h0000800, 2'b00, 0);
        meas(28'h0001000, 2'b00, 0);
        readFlags(0);
        meas(28'h0001001, 2'b10, 1);
        `CHK("pinAbove", 1'b1, irqPinOe)
        // a run of four, broken once by an in-between value
        faultCountSel = 2'h2;
        for (int i = 0; i < 8; i++) begin
            mid = 28'h0000801 + {17'h0, 11'($random(seed))};
            meas((i == 3) ? mid : 28'h00007FF, 2'b01, i == 7);
        end
        `CHK("pinBelow", 1'b0, irqPinOe)
        irqLinePolarity = 1'b1;
        repeat (14) @(negedge clock);
        `CHK("pinPolarity", 1'b1, irqPinOe)
        irqLinePolarity = 1'b0;
        // channel 0 picked by the select
        compareChannelSel = 1'b0;
        faultCountSel = 2'h0;
        meas(28'h00007FF, 2'b10, 1);
        compareChannelSel = 1'b1;
        $display("test transparent done");
        // latched window
        faultCountSel = 2'h0;
        latchMode = 1'b1;
        readFlags(1);
        meas(28'h00007FF, 2'b01, 1);
        meas(28'h0001001, 2'b11, 1);
        meas(28'h0000C00, 2'b11, 0);
        `CHK("pinLatched", 1'b1, irqPinOe)
        readFlags(1);
        `CHK("pinReleased", 1'b0, irqPinOe)
        latchMode = 1'b0;
        $display("test latched done");
        // completion pulses, every one, two and four conversions
        for (int fn = 1; fn < 4; fn++) begin
            irqPinFunction = 2'(fn);
            pulseCount = 0;
            // spacing lets each 1us pulse end first
            repeat (4) begin
                meas(28'h0000C00, 2'b00, 0);
                repeat (40) @(negedge clock);
            end
            repeat (60) @(negedge clock);
            `CHK("pulseCount", 4 >> (fn - 1), pulseCount)
        end
        irqPinFunction = 2'h0;
        $display("test pulses done");
        // forced range reset, with a refused trigger inside it
        trig(1, RST + 1);
        repeat (5) @(negedge clock);
        `CHK("rangeReset", 1'b1, rangeReset)
        trig(2, 0);
        waitDone;
        `CHK("modeClearedForce", 2'h0, modeValue)
        $display("test force done");
        // off: no conversion at all
        trig(0, 0);
        repeat (100) @(negedge clock);
        `CHK("offMode", 2'h0, modeValue)
        // continuous conversions
        contMode = 1'b1;
        startCount = 0;
        trig(3, 0);
        repeat (300) @(negedge clock);
        `CHK("continuousRuns", 1'b1, startCount >= 8)
        `CHK("continuousPower", 1'b1, powered)
        trig(0, 0);
        repeat (40) @(negedge clock);
        contMode = 1'b0;
        repeat (40) @(negedge clock);
        $display("test continuous done");
        pinDirection = 1'b0;
        repeat (10) @(negedge clock);
        trig(2, 1);
        waitDone;
        contMode = 1'b1;
        startCount = 0;
        hostPull = 1'b1;
        repeat (8) @(negedge clock);
        hostPull = 1'b0;
        waitDone;
        `CHK("pinTrigger", 1, startCount)
        `CHK("pinKeepsMode", 2'h2, modeValue)
        `CHK("pinNotDriven", 1'b0, irqPinOe)
        `CHK("pinOutLow", 1'b0, irqPinOut)
        contMode = 1'b0;
        $display("test pin trigger done");
        report_and_stop;
    end
endmodule : light_sensor_mode_irq_ctrl_bench
